//--- spfc_pkg.sv
// shared constants and types for the self-program flash control block
package spfc_pkg;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  localparam logic [5:0] CTRL_ADDR  = 6'h37;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam int EN_BIT   = 0;
  localparam int ERS_BIT  = 1;
  localparam int WR_BIT   = 2;
  localparam int FLR_BIT  = 3;
  localparam int CLEAR_PAGE_BUFFER_BIT_BIT = 4;
  localparam int SIG_BIT  = 5;

  // ------------------------------------------------------------
  // windows and timing
  // ------------------------------------------------------------
  localparam logic [2:0] STORE_WIN = 3'h4;
  localparam logic [2:0] LOAD_WIN  = 3'h3;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TICK_DIV       = 250;
  localparam int TICK_NS        = CLK_PERIOD_NS * TICK_DIV;
  localparam int PROG_MIN_NS    = 3_700_000;
  localparam int PROG_MAX_NS    = 4_500_000;
  localparam int PROG_TICKS     = (PROG_MIN_NS + TICK_NS - 1) / TICK_NS;
  localparam int PROG_MAX_TICKS = PROG_MAX_NS / TICK_NS;

  // ------------------------------------------------------------
  // geometry, fuses, signature
  // ------------------------------------------------------------
  localparam int WORD_W     = 4;
  localparam int PAGE_W     = 7;
  localparam int PAGE_WORDS = 1 << WORD_W;
  localparam int FADDR_W    = WORD_W + PAGE_W;
  localparam int SELF_PROG_FUSE_BIT = 0;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [1:0] SEL_LOW  = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_EXT  = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;
  // arbitrary signature values
  localparam logic [7:0] SIG_BYTE0 = 8'h5a;
  localparam logic [7:0] SIG_BYTE1 = 8'h11;
  localparam logic [7:0] SIG_BYTE2 = 8'h22;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE, ST_LOCK} spfc_state_e;

endpackage

//--- spfc_tick_div.sv
// divider giving the flash timing tick
`timescale 1ns/1ns
module spfc_tick_div (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic restart,
  output logic      tick
);

  typedef struct packed {
    logic [7:0] cnt;
  } spfc_div_s;

  localparam logic [7:0] LAST = 8'(spfc_pkg::TICK_DIV - 1);

  spfc_div_s q;
  spfc_div_s d;

  always_comb begin
    d = q;
    if (!rst_n || restart) begin
      d.cnt = 8'h00;
    end else if (q.cnt == LAST) begin
      d.cnt = 8'h00;
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign tick = (q.cnt == LAST);

endmodule // spfc_tick_div

//--- spfc_page_buf.sv
// temporary page buffer with per-word valid bits
`timescale 1ns/1ns
module spfc_page_buf (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // fill side
  input  wire logic        clr,
  input  wire logic        we,
  input  wire logic [3:0]  widx,
  input  wire logic [15:0] wdata,
  // drain side
  input  wire logic [3:0]  ridx,
  output logic      [15:0] rdata,
  output logic             any_valid
);

  typedef struct packed {
    logic [spfc_pkg::PAGE_WORDS-1:0] valid;
  } spfc_buf_s;

  spfc_buf_s q;
  spfc_buf_s d;
  logic [15:0] mem [spfc_pkg::PAGE_WORDS];
  logic [spfc_pkg::PAGE_WORDS-1:0] valid_n;

  // clear beats a same-cycle load
  for (genvar i = 0; i < spfc_pkg::PAGE_WORDS; i++) begin : g_ent
    assign valid_n[i] = (!rst_n || clr) ? 1'b0 :
                        ((we && widx == 4'(i)) ? 1'b1 : q.valid[i]);
  end

  always_comb begin
    d = q;
    d.valid = valid_n;
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[widx] <= wdata;
    end
  end

  assign rdata     = q.valid[ridx] ? mem[ridx] : spfc_pkg::ERASED_WORD;
  assign any_valid = |q.valid;

endmodule // spfc_page_buf

//--- spfc_ctrl.sv
// self-program flash control: control register, page buffer, flash ops
//
// Function
// - enable-only write plus store within four cycles loads buffer word.
// - buffer cleared after page write, on clear bit, and on reset except during a page write.
// - data memory write start during loading discards buffer.
// - write plus enable then store performs page write of pointer page.
// - core is stalled throughout page erase and page write.
// - pointer low bits pick word, high bits pick page.
// - byte loads use full pointer including bit 0.
// - data memory write busy blocks flash ops and fuse reads.
// - fuse and lock bits read 0 programmed, 1 unprogrammed.
// - pointer 1 in fuse-lock mode returns lock bits.
// - pointers 0, 2, 3 return low, extended, high fuse bytes.
// - pointer bits 1..0 equal to 1 pick lock bits, other values pick fuse bytes.
// - read and enable bits clear after read or three idle cycles.
// - signature mode load returns table entry at pointer.
// - erase, write, lock write timed between 3.7 and 4.5 ms.
// - control at 0x37, resets zero, bits 7..6 read zero.
// - page write bit self-clears on completion or window expiry.
// - page erase bit self-clears on completion or window expiry.
// - enable-only store loads buffer, ignoring pointer bit 0.
// - enable clears after store or expiry, held during erase/write.
// - a flash write in progress completes through a reset.
// - erase plus enable then store erases pointer page.
`timescale 1ns/1ns
module spfc_ctrl #(
  parameter logic [11:0] PROG_TICKS = 12'(spfc_pkg::PROG_TICKS)
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // control register port
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [5:0]  IO_ADDR,
  input  wire logic [7:0]  IO_WDATA,
  output logic      [7:0]  IO_RDATA,
  // core instruction side
  input  wire logic        STORE_STB,
  input  wire logic        LOAD_STB,
  input  wire logic [15:0] PTR,
  input  wire logic [15:0] DATA_PAIR,
  output logic      [7:0]  LOAD_DATA,
  output logic             LOAD_DONE,
  output logic             CORE_STALL,
  // nonvolatile state
  input  wire logic        DATA_MEM_WRITE_BUSY,
  input  wire logic [7:0]  LOW_FUSE_BYTE,
  input  wire logic [7:0]  HIGH_FUSE_BYTE,
  input  wire logic [7:0]  EXT_FUSE_BYTE,
  input  wire logic [7:0]  LOCK_BITS,
  // flash array
  output logic      [10:0] FL_RD_ADDR,
  input  wire logic [15:0] FL_RD_DATA,
  output logic             FL_ERASE,
  output logic             FL_WR_EN,
  output logic      [10:0] FL_ADDR,
  output logic      [15:0] FL_WDATA,
  output logic             FL_LOCK_WR,
  output logic      [7:0]  FL_LOCK_DATA
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    spfc_pkg::spfc_state_e st;
    logic [5:0]            ctrl;
    logic [2:0]            win;
    logic                  loading;
    logic                  busy_prev;
    logic [11:0]           timer;
    logic [4:0]            widx;
    logic [6:0]            page;
    logic [7:0]            rdata;
    logic [7:0]            ld_data;
    logic                  ld_done;
    logic                  fl_erase;
    logic                  fl_wr_en;
    logic [10:0]           fl_addr;
    logic [15:0]           fl_wdata;
    logic                  fl_lock_wr;
    logic [7:0]            fl_lock_data;
  } spfc_main_s;

  spfc_main_s q;
  spfc_main_s d;

  logic        buf_we;
  logic        buf_clr;
  logic [15:0] buf_rdata;
  logic        buf_any;
  logic        tick;
  logic        tick_restart;
  logic        idle;
  logic        armed;
  logic        reg_wr;
  logic        reg_rd;
  logic        store_ok;
  logic        fuse_mode;
  logic        sig_mode;
  logic        op_done;
  logic [3:0]  ptr_word;
  logic [6:0]  ptr_page;
  logic [7:0]  fuse_sel;
  logic [7:0]  sig_sel;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign idle     = (q.st == spfc_pkg::ST_IDLE);
  assign armed    = idle && (q.win != 3'h0) && q.ctrl[spfc_pkg::EN_BIT];
  // pointer split into word and page fields
  assign ptr_word = PTR[spfc_pkg::WORD_W:1];
  assign ptr_page = PTR[spfc_pkg::FADDR_W:spfc_pkg::WORD_W+1];

  assign reg_rd   = IO_RD && (IO_ADDR == spfc_pkg::CTRL_ADDR);
  // writes locked out while busy or an op runs
  assign reg_wr   = IO_WR && (IO_ADDR == spfc_pkg::CTRL_ADDR)
                    && idle && !DATA_MEM_WRITE_BUSY;

  // store needs open window, fuse programmed, no busy
  assign store_ok = STORE_STB && armed && !DATA_MEM_WRITE_BUSY
                    && !EXT_FUSE_BYTE[spfc_pkg::SELF_PROG_FUSE_BIT];

  assign fuse_mode = armed && q.ctrl[spfc_pkg::FLR_BIT] && !DATA_MEM_WRITE_BUSY;
  assign sig_mode  = armed && q.ctrl[spfc_pkg::SIG_BIT];

  assign op_done  = !idle && tick && (q.timer == PROG_TICKS - 12'h001);

  // bits 1..0: 1 picks lock bits, 0, 2, 3 pick low, extended, high fuse byte
  always_comb begin
    unique case (PTR[1:0])
      spfc_pkg::SEL_LOW:  fuse_sel = LOW_FUSE_BYTE;
      spfc_pkg::SEL_LOCK: fuse_sel = LOCK_BITS;
      spfc_pkg::SEL_EXT:  fuse_sel = EXT_FUSE_BYTE;
      spfc_pkg::SEL_HIGH: fuse_sel = HIGH_FUSE_BYTE;
    endcase
  end

  // signature table lookup
  always_comb begin
    unique case (PTR[1:0])
      2'h0:    sig_sel = spfc_pkg::SIG_BYTE0;
      2'h1:    sig_sel = spfc_pkg::SIG_BYTE1;
      2'h2:    sig_sel = spfc_pkg::SIG_BYTE2;
      default: sig_sel = 8'hff;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d            = q;
    buf_we       = 1'b0;
    buf_clr      = 1'b0;
    tick_restart = 1'b0;
    d.busy_prev  = DATA_MEM_WRITE_BUSY;
    d.ld_done    = 1'b0;
    d.fl_erase   = 1'b0;
    d.fl_wr_en   = 1'b0;
    d.fl_lock_wr = 1'b0;

    // reserved bits read zero
    if (reg_rd) begin
      d.rdata = {2'b00, q.ctrl};
    end

    // window count-down; expiry drops every command bit
    if (idle && q.win != 3'h0) begin
      d.win = q.win - 3'h1;
      if (q.win == 3'h1) begin
        d.ctrl = spfc_pkg::CTRL_RESET;
      end
    end

    if (reg_wr) begin
      if (IO_WDATA[spfc_pkg::CLEAR_PAGE_BUFFER_BIT_BIT]) begin
        buf_clr   = 1'b1;
        d.loading = 1'b0;
      end
      // bits 7..6 dropped, clear bit never stored
      if (IO_WDATA[spfc_pkg::EN_BIT]) begin
        d.ctrl = IO_WDATA[5:0];
        d.ctrl[spfc_pkg::CLEAR_PAGE_BUFFER_BIT_BIT] = 1'b0;
        d.win  = (IO_WDATA[spfc_pkg::FLR_BIT] || IO_WDATA[spfc_pkg::SIG_BIT])
                 ? spfc_pkg::LOAD_WIN : spfc_pkg::STORE_WIN;
      end else begin
        d.ctrl = spfc_pkg::CTRL_RESET;
        d.win  = 3'h0;
      end
    end

    // loads: byte chosen by pointer bit 0
    if (LOAD_STB && idle) begin
      d.ld_done = 1'b1;
      d.ld_data = PTR[0] ? FL_RD_DATA[15:8] : FL_RD_DATA[7:0];
      if (fuse_mode) begin
        d.ld_data = fuse_sel;
        d.ctrl    = spfc_pkg::CTRL_RESET;
        d.win     = 3'h0;
      end else if (sig_mode) begin
        d.ld_data = sig_sel;
        d.ctrl    = spfc_pkg::CTRL_RESET;
        d.win     = 3'h0;
      end
    end

    if (store_ok) begin
      d.win  = 3'h0;
      d.ctrl = spfc_pkg::CTRL_RESET;
      d.page = ptr_page;
      d.timer = 12'h000;
      if (q.ctrl[spfc_pkg::ERS_BIT]) begin
        // enable and erase bit held until done
        d.st       = spfc_pkg::ST_ERASE;
        d.ctrl     = q.ctrl;
        d.fl_erase = 1'b1;
        d.fl_addr  = {ptr_page, 4'h0};
        tick_restart = 1'b1;
      end else if (q.ctrl[spfc_pkg::WR_BIT]) begin
        // data pair ignored for page write
        d.st   = spfc_pkg::ST_WRITE;
        d.ctrl = q.ctrl;
        d.widx = 5'h00;
        tick_restart = 1'b1;
      end else if (q.ctrl[spfc_pkg::FLR_BIT]) begin
        d.st           = spfc_pkg::ST_LOCK;
        d.fl_lock_wr   = 1'b1;
        d.fl_lock_data = DATA_PAIR[7:0];
        tick_restart   = 1'b1;
      end else if (!q.ctrl[spfc_pkg::SIG_BIT]) begin
        buf_we    = 1'b1;
        d.loading = 1'b1;
      end
    end

    // running operation: stream page, count ticks
    if (!idle) begin
      if (q.st == spfc_pkg::ST_WRITE && q.widx < 5'(spfc_pkg::PAGE_WORDS)) begin
        d.fl_wr_en = 1'b1;
        d.fl_addr  = {q.page, q.widx[3:0]};
        d.fl_wdata = buf_rdata;
        d.widx     = q.widx + 5'h01;
      end
      if (tick) begin
        d.timer = q.timer + 12'h001;
      end
      if (op_done) begin
        d.st    = spfc_pkg::ST_IDLE;
        d.ctrl  = spfc_pkg::CTRL_RESET;
        d.timer = 12'h000;
        if (q.st == spfc_pkg::ST_WRITE) begin
          buf_clr   = 1'b1;
          d.loading = 1'b0;
        end
      end
    end

    // data memory write start loses loaded words
    if (DATA_MEM_WRITE_BUSY && !q.busy_prev && q.loading) begin
      buf_clr   = 1'b1;
      d.loading = 1'b0;
    end

    // reset keeps a running op alive, else clears all
    if (!RST_N) begin
      if (q.st inside {spfc_pkg::ST_ERASE, spfc_pkg::ST_WRITE, spfc_pkg::ST_LOCK}) begin
        d.win       = 3'h0;
        d.rdata     = 8'h00;
        d.ld_data   = 8'h00;
        d.ld_done   = 1'b0;
        d.busy_prev = 1'b0;
        d.loading   = 1'b0;
        if (q.st != spfc_pkg::ST_WRITE) begin
          buf_clr = 1'b1;
        end
      end else begin
        d       = '0;
        buf_clr = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    q <= d;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  spfc_page_buf u_buf (
    .clk       (CLK_SYS),
    .rst_n     (1'b1),
    .clr       (buf_clr),
    .we        (buf_we),
    .widx      (ptr_word),
    .wdata     (DATA_PAIR),
    .ridx      (q.widx[3:0]),
    .rdata     (buf_rdata),
    .any_valid (buf_any)
  );

  spfc_tick_div u_div (
    .clk     (CLK_SYS),
    .rst_n   (RST_N || !idle),
    .restart (tick_restart),
    .tick    (tick)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign CORE_STALL   = !idle;
  assign FL_RD_ADDR   = PTR[spfc_pkg::FADDR_W:1];
  assign IO_RDATA     = q.rdata;
  assign LOAD_DATA    = q.ld_data;
  assign LOAD_DONE    = q.ld_done;
  assign FL_ERASE     = q.fl_erase;
  assign FL_WR_EN     = q.fl_wr_en;
  assign FL_ADDR      = q.fl_addr;
  assign FL_WDATA     = q.fl_wdata;
  assign FL_LOCK_WR   = q.fl_lock_wr;
  assign FL_LOCK_DATA = q.fl_lock_data;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  localparam int OP_CYC = 21'(PROG_TICKS) * spfc_pkg::TICK_DIV;

  logic [20:0] op_cyc;

  always_ff @(posedge CLK_SYS) begin
    op_cyc <= idle ? 21'h000000 : op_cyc + 21'h000001;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  AST_OP_STALL: assert property (
    !idle |-> CORE_STALL && (q.st == spfc_pkg::ST_LOCK || q.ctrl[spfc_pkg::EN_BIT]))
    else $error("op running without stall or enable");

  AST_WIN_EXPIRE: assert property (
    idle && q.win == 3'h1 && !STORE_STB && !LOAD_STB && !reg_wr
    |=> q.ctrl == 6'h00 && q.win == 3'h0)
    else $error("command bits survived window expiry");

  AST_LATE_STORE: assert property (
    idle && q.win == 3'h0 && STORE_STB |-> !buf_we ##1 idle)
    else $error("store outside window took effect");

  AST_OP_TIME: assert property (
    $fell(!idle) |-> op_cyc == 21'(OP_CYC))
    else $error("flash op length wrong");

  AST_RSV_ZERO: assert property (
    reg_rd |=> IO_RDATA[7:6] == 2'b00 && IO_RDATA[5:0] == $past(q.ctrl))
    else $error("control readback wrong");

  AST_BUSY_BLOCK: assert property (
    DATA_MEM_WRITE_BUSY && STORE_STB && idle |-> !buf_we ##1 idle)
    else $error("store ran during data memory write");

  AST_FUSE_LOW: assert property (
    LOAD_STB && fuse_mode && PTR[1:0] == 2'b00
    |=> LOAD_DONE && LOAD_DATA == $past(LOW_FUSE_BYTE))
    else $error("low fuse byte not returned");

  AST_LOCK_READ: assert property (
    LOAD_STB && fuse_mode && PTR[1:0] == 2'b01
    |=> LOAD_DATA == $past(LOCK_BITS) && q.ctrl == 6'h00)
    else $error("lock read wrong or bits not cleared");

  AST_BUF_CLR: assert property (
    q.st == spfc_pkg::ST_WRITE ##1 idle |-> !buf_any && !q.loading)
    else $error("buffer not cleared after page write");

  AST_LOAD_LOST: assert property (
    DATA_MEM_WRITE_BUSY && !q.busy_prev && q.loading |=> !buf_any)
    else $error("buffer kept across data memory write");

  AST_PAGE_LOAD: assert property (
    store_ok && q.ctrl == 6'h01 |=> idle && q.ctrl == 6'h00 && buf_any)
    else $error("page load misbehaved");

  COV_ERASE: cover property (store_ok && q.ctrl[spfc_pkg::ERS_BIT]);
  COV_WRITE_DONE: cover property (q.st == spfc_pkg::ST_WRITE ##1 idle);
  COV_FUSE_READ: cover property (LOAD_STB && fuse_mode);
  COV_SIG_READ: cover property (LOAD_STB && sig_mode);

endmodule // spfc_ctrl

//--- spfc_flash_model.sv
// flash array model for the self-program flash control bench
`timescale 1ns/1ns
module spfc_flash_model (
  // clock
  input  wire logic        clk,
  // read port
  input  wire logic [10:0] rd_addr,
  output logic      [15:0] rd_data,
  // program port
  input  wire logic        erase,
  input  wire logic        wr_en,
  input  wire logic [10:0] addr,
  input  wire logic [15:0] wdata
);
  logic [15:0] mem [0:2047];

  // array starts erased
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 16'hffff;
    end
  end

  // asynchronous read
  assign rd_data = mem[rd_addr];

  // erase sets a whole page, write takes one word
  always @(posedge clk) begin
    if (erase) begin
      for (int i = 0; i < 16; i++) begin
        mem[{addr[10:4], 4'(i)}] <= 16'hffff;
      end
    end
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end
endmodule // spfc_flash_model

//--- spfc_ctrl_test.sv
// testbench for the self-program flash control block
`timescale 1ns/1ns
module spfc_ctrl_test;
  localparam int STALL = 4 * spfc_pkg::TICK_DIV;
  logic        clk, rst_n, io_wr, io_rd, st_stb, ld_stb, busy;
  logic        ld_done, stall, fl_erase, fl_wr_en, fl_lock_wr;
  logic [7:0]  fl_lock_data;
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, ld_data, fuse_lo, fuse_hi, fuse_ex, lock;
  logic [10:0] fl_rd_addr, fl_addr;
  logic [15:0] ptr, dpair, fl_rdata, fl_wdata;
  int          fails, cmp_count;

  spfc_ctrl #(.PROG_TICKS(12'h004)) dut_u (
    .CLK_SYS(clk), .RST_N(rst_n), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
    .STORE_STB(st_stb), .LOAD_STB(ld_stb), .PTR(ptr), .DATA_PAIR(dpair),
    .LOAD_DATA(ld_data), .LOAD_DONE(ld_done), .CORE_STALL(stall),
    .DATA_MEM_WRITE_BUSY(busy), .LOW_FUSE_BYTE(fuse_lo),
    .HIGH_FUSE_BYTE(fuse_hi), .EXT_FUSE_BYTE(fuse_ex), .LOCK_BITS(lock),
    .FL_RD_ADDR(fl_rd_addr), .FL_RD_DATA(fl_rdata), .FL_ERASE(fl_erase),
    .FL_WR_EN(fl_wr_en), .FL_ADDR(fl_addr), .FL_WDATA(fl_wdata),
    .FL_LOCK_WR(fl_lock_wr), .FL_LOCK_DATA(fl_lock_data));

  spfc_flash_model flash_u (
    .clk(clk), .rd_addr(fl_rd_addr), .rd_data(fl_rdata), .erase(fl_erase),
    .wr_en(fl_wr_en), .addr(fl_addr), .wdata(fl_wdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // --------------------
  // shared tasks
  // --------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp, input string msg);
    cmp_count++;
    if (got != exp) begin
      fails++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  function automatic logic [15:0] ba(input int pg, input int w, input int b);
    return 16'((pg << 5) | (w << 1) | b);
  endfunction

  function automatic logic [15:0] wd(input int w);
    return {4'ha, 4'(w), 4'h5, 4'(w)};
  endfunction

  task automatic wr(input logic [7:0] d);
    io_wr = 1'b1;
    io_wdata = d;
    cyc(1);
    io_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] exp, input string msg);
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    chk8(io_rdata, exp, msg);
  endtask

  task automatic st(input logic [15:0] p, input logic [15:0] d);
    ptr = p;
    dpair = d;
    st_stb = 1'b1;
    cyc(1);
    st_stb = 1'b0;
  endtask

  task automatic ld(input logic [15:0] p, input logic [7:0] exp, input string msg);
    ptr = p;
    ld_stb = 1'b1;
    cyc(1);
    ld_stb = 1'b0;
    chk8({7'h0, ld_done}, 8'h01, msg);
    chk8(ld_data, exp, msg);
    cyc(1);
  endtask

  // timed erase or write; optional reset pulse part way through
  task automatic op(input logic [7:0] cmd, input int pg, input int rst_at);
    int n;
    wr(cmd);
    st(ba(pg, 0, 0), 16'h0000);
    rd(cmd, "control during op");
    n = 1;
    while (stall === 1'b1 && n < 5000) begin
      if (n == rst_at) rst_n = 1'b0;
      if (n == rst_at + 2) rst_n = 1'b1;
      n++;
      cyc(1);
    end
    chkn(n, STALL, "stall length");
    rd(8'h00, "control after op");
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic t_reg();
    rd(8'h00, "reset value");
    wr(8'hc1);
    rd(8'h01, "reserved bits");
    cyc(4);
    rd(8'h00, "enable expiry");
    io_addr = 6'h36;
    wr(8'h01);
    io_addr = 6'h37;
    rd(8'h00, "unmapped write");
  endtask

  task automatic t_fill();
    logic [15:0] e;
    // each buffer word except word 5 loaded once between clears
    for (int w = 0; w < 16; w++) begin
      if (w != 5) begin
        wr(8'h01);
        st(ba(3, w, w % 2), wd(w));
      end
    end
    op(8'h03, 3, 0);
    op(8'h05, 3, 0);
    for (int w = 0; w < 16; w++) begin
      e = (w == 5) ? 16'hffff : wd(w);
      ld(ba(3, w, 0), e[7:0], "page low byte");
      ld(ba(3, w, 1), e[15:8], "page high byte");
    end
    op(8'h05, 3, 0);
    ld(ba(3, 1, 0), 8'hff, "buffer after write");
  endtask

  task automatic t_fuse();
    logic [7:0] exp [4];
    logic [7:0] sig [4];
    exp = '{fuse_lo, lock, fuse_ex, fuse_hi};
    sig = '{spfc_pkg::SIG_BYTE0, spfc_pkg::SIG_BYTE1, spfc_pkg::SIG_BYTE2, 8'hff};
    for (int p = 0; p < 4; p++) begin
      wr(8'h09);
      ld(16'(p), exp[p], "fuse lock read");
      rd(8'h00, "read bits cleared");
    end
    ld(16'h0000, 8'hff, "normal load");
    wr(8'h09);
    cyc(3);
    ld(16'h0001, 8'hff, "late fuse load");
    for (int p = 0; p < 4; p++) begin
      wr(8'h21);
      ld(16'(p), sig[p], "signature");
    end
  endtask

  task automatic t_late();
    wr(8'h01);
    cyc(5);
    st(ba(9, 0, 0), 16'h1234);
    wr(8'h05);
    cyc(5);
    st(ba(9, 0, 0), 16'h0000);
    chk8({7'h0, stall}, 8'h00, "late write store");
    fuse_ex = 8'hff;
    wr(8'h05);
    st(ba(9, 0, 0), 16'h0000);
    chk8({7'h0, stall}, 8'h00, "fuse gate");
    fuse_ex = 8'hfe;
    op(8'h05, 9, 0);
    ld(ba(9, 0, 0), 8'hff, "late store dropped");
  endtask

  task automatic t_busy();
    busy = 1'b1;
    wr(8'h09);
    ld(16'h0000, 8'hff, "fuse read in busy");
    rd(8'h00, "write in busy");
    busy = 1'b0; // busy clear before control writes
    wr(8'h01);
    st(ba(7, 0, 0), 16'h1234);
    busy = 1'b1;
    cyc(1);
    busy = 1'b0;
    op(8'h05, 7, 0);
    ld(ba(7, 0, 0), 8'hff, "buffer after busy");
    wr(8'h01);
    st(ba(8, 0, 0), 16'h1234);
    wr(8'h10);
    cyc(1);
    op(8'h05, 8, 0);
    ld(ba(8, 0, 0), 8'hff, "buffer after clear");
  endtask

  task automatic t_reset();
    wr(8'h01);
    st(ba(11, 0, 0), 16'h1234);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    op(8'h05, 11, 0);
    ld(ba(11, 0, 0), 8'hff, "buffer after reset");
    op(8'h03, 11, 40);
  endtask

  // lock-bit write: timed op, data from the low byte of the pair
  task automatic t_lock();
    wr(8'h09);
    st(16'h0001, 16'h00f3);
    chk8({7'h0, fl_lock_wr}, 8'h01, "lock write start");
    chk8(fl_lock_data, 8'hf3, "lock write data");
    chk8({7'h0, stall}, 8'h01, "lock stall start");
    cyc(STALL - 1);
    chk8({7'h0, stall}, 8'h01, "lock stall last");
    cyc(1);
    chk8({7'h0, stall}, 8'h00, "lock stall over");
    rd(8'h00, "control after lock");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (50 * STALL) @(posedge clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    {rst_n, io_wr, io_rd, st_stb, ld_stb, busy} = '0;
    io_addr = 6'h37;
    io_wdata = 8'h00;
    ptr = 16'h0000;
    dpair = 16'h0000;
    fuse_lo = 8'h62;
    fuse_hi = 8'hdf;
    fuse_ex = 8'hfe;
    lock = 8'hfc;
    fails = 0;
    cmp_count = 0;
    cyc(8);
    rst_n = 1'b1;
    t_reg();
    t_fill();
    t_fuse();
    t_late();
    t_busy();
    t_reset();
    t_lock();
    stop_test();
  end
endmodule // spfc_ctrl_test
